// [logic/bfp_consts.vh]
// Shared constants of the bidirectional queue port block
`ifndef BFP_CONSTS_VH
`define BFP_CONSTS_VH

// ************************************************************
// Widths and sizes
// ************************************************************
`define BFP_DATA_W        36
`define BFP_DEPTH         256
`define BFP_CTL_W         6
`define BFP_LOW_OFS       8
`define BFP_HIGH_OFS      8

// ************************************************************
// Reset values
// ************************************************************
`define BFP_CTL_RST       6'h08
`define BFP_DATA_RST      36'h0
`define BFP_MAIL_EMPTY    1'b1
`define BFP_MAIL_FULL     1'b0

// ************************************************************
// Timing mode encodings
// ************************************************************
`define BFP_MODE_STD      1'b1
`define BFP_MODE_FT       1'b0

// ************************************************************
// Timing
// ************************************************************
`define BFP_REF_PERIOD_NS 10
`define BFP_SKEW_NS       5
`define BFP_SKEW_CYC ((`BFP_SKEW_NS + `BFP_REF_PERIOD_NS - 1) / `BFP_REF_PERIOD_NS)

`endif

// [logic/bfp_sync.v]
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module bfp_sync #(
  parameter         W   = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  ref_clk,
  rst_n,
  d,
  q
);
  input  wire         ref_clk;
  input  wire         rst_n;
  input  wire [W-1:0] d;
  output wire [W-1:0] q;

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST;
      sync_ff <= RST;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule

// [logic/bfp_ram.v]
// Queue storage array, one write port, asynchronous read
`timescale 1ns/1ps
module bfp_ram #(
  parameter W  = 36,
  parameter AW = 8
) (
  ref_clk,
  wr_en,
  wr_addr,
  wr_data,
  rd_addr,
  rd_data
);
  input  wire          ref_clk;
  input  wire          wr_en;
  input  wire [AW-1:0] wr_addr;
  input  wire [W-1:0]  wr_data;
  input  wire [AW-1:0] rd_addr;
  output wire [W-1:0]  rd_data;

  reg [W-1:0] mem_ff [0:(1<<AW)-1];

  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem_ff[rd_addr];
endmodule

// [logic/bfp_top.v]
// Port access, queues, mailboxes and flags of the bidirectional FIFO
`timescale 1ns/1ps
`include "bfp_consts.vh"

module bfp_top #(
  parameter DEPTH    = `BFP_DEPTH,
  parameter LOW_OFS  = `BFP_LOW_OFS,
  parameter HIGH_OFS = `BFP_HIGH_OFS,
  parameter SKEW_CYC = `BFP_SKEW_CYC
) (
  ref_clk,
  rst_n,
  endian_timing_select,
  a_clk,
  a_select_n,
  a_dir,
  a_enable,
  a_mail_sel,
  a_data_i,
  a_data_o,
  a_data_oe,
  a_avail_flag,
  a_space_flag,
  a_low_fill_flag,
  a_high_fill_flag,
  b_clk,
  b_select_n,
  b_dir,
  b_enable,
  b_mail_sel,
  b_data_i,
  b_data_o,
  b_data_oe,
  b_avail_flag,
  b_space_flag,
  b_low_fill_flag,
  b_high_fill_flag,
  a_to_b_mail_flag,
  b_to_a_mail_flag
);
  localparam DW = `BFP_DATA_W;
  localparam SW = `BFP_CTL_W + `BFP_DATA_W;
  localparam AW = $clog2(DEPTH);
  localparam [AW:0] DEPTH_P  = DEPTH;
  localparam [AW:0] LOW_LIM  = LOW_OFS;
  localparam [AW:0] HIGH_LIM = DEPTH - HIGH_OFS;
  localparam [AW:0] ONE      = 1;
  localparam [AW:0] ZERO     = 0;
  localparam [1:0]  ST_CAPT  = 2'h1;
  localparam [1:0]  ST_RUN   = 2'h2;

  input  wire          ref_clk;
  input  wire          rst_n;
  input  wire          endian_timing_select;
  input  wire          a_clk;
  input  wire          a_select_n;
  input  wire          a_dir;
  input  wire          a_enable;
  input  wire          a_mail_sel;
  input  wire [DW-1:0] a_data_i;
  output wire [DW-1:0] a_data_o;
  output wire          a_data_oe;
  output wire          a_avail_flag;
  output wire          a_space_flag;
  output wire          a_low_fill_flag;
  output wire          a_high_fill_flag;
  input  wire          b_clk;
  input  wire          b_select_n;
  input  wire          b_dir;
  input  wire          b_enable;
  input  wire          b_mail_sel;
  input  wire [DW-1:0] b_data_i;
  output wire [DW-1:0] b_data_o;
  output wire          b_data_oe;
  output wire          b_avail_flag;
  output wire          b_space_flag;
  output wire          b_low_fill_flag;
  output wire          b_high_fill_flag;
  output wire          a_to_b_mail_flag;
  output wire          b_to_a_mail_flag;

  // ************************************************************
  // Pin synchronisers and port clock edges
  // ************************************************************
  wire [SW-1:0] a_sync;
  wire [SW-1:0] b_sync;

  bfp_sync #(.W(SW), .RST({`BFP_CTL_RST, `BFP_DATA_RST})) u_sync_a (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       ({endian_timing_select, a_clk, a_select_n, a_dir,
                a_enable, a_mail_sel, a_data_i}),
    .q       (a_sync)
  );

  bfp_sync #(.W(SW), .RST({`BFP_CTL_RST, `BFP_DATA_RST})) u_sync_b (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       ({endian_timing_select, b_clk, b_select_n, b_dir,
                b_enable, b_mail_sel, b_data_i}),
    .q       (b_sync)
  );

  wire          a_ets_s  = a_sync[SW-1];
  wire          a_clk_s  = a_sync[SW-2];
  wire          a_seln_s = a_sync[SW-3];
  wire          a_dir_s  = a_sync[SW-4];
  wire          a_en_s   = a_sync[SW-5];
  wire          a_mail_s = a_sync[SW-6];
  wire [DW-1:0] a_din_s  = a_sync[DW-1:0];
  wire          b_ets_s  = b_sync[SW-1];
  wire          b_clk_s  = b_sync[SW-2];
  wire          b_seln_s = b_sync[SW-3];
  wire          b_dir_s  = b_sync[SW-4];
  wire          b_en_s   = b_sync[SW-5];
  wire          b_mail_s = b_sync[SW-6];
  wire [DW-1:0] b_din_s  = b_sync[DW-1:0];

  reg a_clk_d_ff;
  reg b_clk_d_ff;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_clk_d_ff <= 1'b0;
      b_clk_d_ff <= 1'b0;
    end else begin
      a_clk_d_ff <= a_clk_s;
      b_clk_d_ff <= b_clk_s;
    end
  end

  wire a_edge = a_clk_s & ~a_clk_d_ff;
  wire b_edge = b_clk_s & ~b_clk_d_ff;

  // ************************************************************
  // Port function decode
  // ************************************************************
  wire a_act = a_edge & ~a_seln_s & a_en_s;
  wire b_act = b_edge & ~b_seln_s & b_en_s;

  wire a_q_wr  = a_act & a_dir_s & ~a_mail_s & a_space_flag;
  wire a_q_rd  = a_act & ~a_dir_s & ~a_mail_s;
  wire a_mb_wr = a_act & a_dir_s & a_mail_s;
  wire a_mb_rd = a_act & ~a_dir_s & a_mail_s;
  wire b_q_wr  = b_act & ~b_dir_s & ~b_mail_s & b_space_flag;
  wire b_q_rd  = b_act & b_dir_s & ~b_mail_s;
  wire b_mb_wr = b_act & ~b_dir_s & b_mail_s;
  wire b_mb_rd = b_act & b_dir_s & b_mail_s;

  // Bus direction ignores the enable
  assign a_data_oe = ~a_seln_s & ~a_dir_s;
  assign b_data_oe = ~b_seln_s & b_dir_s;

  // ************************************************************
  // Timing mode capture
  // ************************************************************
  reg [1:0] ab_st_ff;
  reg [1:0] ba_st_ff;
  reg [1:0] nxt_ab_st;
  reg [1:0] nxt_ba_st;
  reg       ab_mode_ff;
  reg       ba_mode_ff;

  always @* begin
    nxt_ab_st = ab_st_ff;
    case (ab_st_ff)
      ST_CAPT: nxt_ab_st = a_edge ? ST_RUN : ST_CAPT;
      ST_RUN:  nxt_ab_st = ST_RUN;
      default: nxt_ab_st = ST_CAPT;
    endcase
  end

  always @* begin
    nxt_ba_st = ba_st_ff;
    case (ba_st_ff)
      ST_CAPT: nxt_ba_st = b_edge ? ST_RUN : ST_CAPT;
      ST_RUN:  nxt_ba_st = ST_RUN;
      default: nxt_ba_st = ST_CAPT;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ab_st_ff   <= ST_CAPT;
      ba_st_ff   <= ST_CAPT;
      ab_mode_ff <= `BFP_MODE_FT;
      ba_mode_ff <= `BFP_MODE_FT;
    end else begin
      ab_st_ff <= nxt_ab_st;
      ba_st_ff <= nxt_ba_st;
      if (ab_st_ff[0] & a_edge) begin
        ab_mode_ff <= a_ets_s;
      end
      if (ba_st_ff[0] & b_edge) begin
        ba_mode_ff <= b_ets_s;
      end
    end
  end

  wire ab_run = ab_st_ff[1];
  wire ba_run = ba_st_ff[1];
  wire ab_std = (ab_mode_ff == `BFP_MODE_STD);
  wire ba_std = (ba_mode_ff == `BFP_MODE_STD);

  // ************************************************************
  // Queue pointers and crossing of pointers
  // ************************************************************
  reg [AW:0] ab_wp_ff;
  reg [AW:0] ab_rp_ff;
  reg [AW:0] ba_wp_ff;
  reg [AW:0] ba_rp_ff;
  reg [AW:0] ab_wdly_ff [0:SKEW_CYC-1];
  reg [AW:0] ba_wdly_ff [0:SKEW_CYC-1];
  reg [AW:0] ab_ws1_ff;
  reg [AW:0] ab_ws2_ff;
  reg [AW:0] ba_ws1_ff;
  reg [AW:0] ba_ws2_ff;
  reg [AW:0] ab_rs1_ff;
  reg [AW:0] ab_rs2_ff;
  reg [AW:0] ba_rs1_ff;
  reg [AW:0] ba_rs2_ff;
  integer    i;

  // Skew delay keeps a late write out of the current read edge
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < SKEW_CYC; i = i + 1) begin
        ab_wdly_ff[i] <= ZERO;
        ba_wdly_ff[i] <= ZERO;
      end
    end else begin
      ab_wdly_ff[0] <= ab_wp_ff;
      ba_wdly_ff[0] <= ba_wp_ff;
      for (i = 1; i < SKEW_CYC; i = i + 1) begin
        ab_wdly_ff[i] <= ab_wdly_ff[i-1];
        ba_wdly_ff[i] <= ba_wdly_ff[i-1];
      end
    end
  end

  // Stages advance only on the reading or writing port's edge
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ab_ws1_ff <= ZERO;
      ab_ws2_ff <= ZERO;
      ba_ws1_ff <= ZERO;
      ba_ws2_ff <= ZERO;
      ab_rs1_ff <= ZERO;
      ab_rs2_ff <= ZERO;
      ba_rs1_ff <= ZERO;
      ba_rs2_ff <= ZERO;
    end else begin
      if (b_edge) begin
        ab_ws1_ff <= ab_wdly_ff[SKEW_CYC-1];
        ab_ws2_ff <= ab_ws1_ff;
        ba_rs1_ff <= ba_rp_ff;
        ba_rs2_ff <= ba_rs1_ff;
      end
      if (a_edge) begin
        ba_ws1_ff <= ba_wdly_ff[SKEW_CYC-1];
        ba_ws2_ff <= ba_ws1_ff;
        ab_rs1_ff <= ab_rp_ff;
        ab_rs2_ff <= ab_rs1_ff;
      end
    end
  end

  // Occupancy seen by each side, output register excluded
  wire [AW:0] ab_rd_cnt = ab_ws2_ff - ab_rp_ff;
  wire [AW:0] ba_rd_cnt = ba_ws2_ff - ba_rp_ff;
  wire [AW:0] ab_wr_cnt = ab_wp_ff - ab_rs2_ff;
  wire [AW:0] ba_wr_cnt = ba_wp_ff - ba_rs2_ff;
  wire        ab_has    = (ab_rd_cnt != ZERO);
  wire        ba_has    = (ba_rd_cnt != ZERO);

  // ************************************************************
  // Storage
  // ************************************************************
  wire [DW-1:0] ab_rd_data;
  wire [DW-1:0] ba_rd_data;

  bfp_ram #(.W(DW), .AW(AW)) u_ram_ab (
    .ref_clk (ref_clk),
    .wr_en   (a_q_wr),
    .wr_addr (ab_wp_ff[AW-1:0]),
    .wr_data (a_din_s),
    .rd_addr (ab_rp_ff[AW-1:0]),
    .rd_data (ab_rd_data)
  );

  bfp_ram #(.W(DW), .AW(AW)) u_ram_ba (
    .ref_clk (ref_clk),
    .wr_en   (b_q_wr),
    .wr_addr (ba_wp_ff[AW-1:0]),
    .wr_data (b_din_s),
    .rd_addr (ba_rp_ff[AW-1:0]),
    .rd_data (ba_rd_data)
  );

  // ************************************************************
  // Output register load, both timing modes
  // ************************************************************
  reg ab_or_ff;
  reg ba_or_ff;

  wire ab_load = ab_std ? (b_q_rd & ab_has) :
                 (ab_has & (~ab_or_ff | b_q_rd));
  wire ba_load = ba_std ? (a_q_rd & ba_has) :
                 (ba_has & (~ba_or_ff | a_q_rd));
  wire ab_ld   = b_edge & ab_load;
  wire ba_ld   = a_edge & ba_load;

  reg [DW-1:0] ab_out_ff;
  reg [DW-1:0] ba_out_ff;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ab_wp_ff  <= ZERO;
      ba_wp_ff  <= ZERO;
      ab_rp_ff  <= ZERO;
      ba_rp_ff  <= ZERO;
      ab_or_ff  <= 1'b0;
      ba_or_ff  <= 1'b0;
      ab_out_ff <= `BFP_DATA_RST;
      ba_out_ff <= `BFP_DATA_RST;
    end else begin
      if (a_q_wr) begin
        ab_wp_ff <= ab_wp_ff + ONE;
      end
      if (b_q_wr) begin
        ba_wp_ff <= ba_wp_ff + ONE;
      end
      if (ab_ld) begin
        ab_out_ff <= ab_rd_data;
        ab_rp_ff  <= ab_rp_ff + ONE;
      end
      if (ba_ld) begin
        ba_out_ff <= ba_rd_data;
        ba_rp_ff  <= ba_rp_ff + ONE;
      end
      // Ready drops once the shown word is taken and none follows
      if (ab_ld) begin
        ab_or_ff <= 1'b1;
      end else if (b_edge & b_q_rd) begin
        ab_or_ff <= 1'b0;
      end
      if (ba_ld) begin
        ba_or_ff <= 1'b1;
      end else if (a_edge & a_q_rd) begin
        ba_or_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  assign b_avail_flag     = ab_std ? ab_has : ab_or_ff;
  assign a_avail_flag     = ba_std ? ba_has : ba_or_ff;
  assign a_space_flag     = ab_run & (ab_wr_cnt != DEPTH_P);
  assign b_space_flag     = ba_run & (ba_wr_cnt != DEPTH_P);
  assign b_low_fill_flag  = (ab_rd_cnt > LOW_LIM);
  assign a_low_fill_flag  = (ba_rd_cnt > LOW_LIM);
  assign a_high_fill_flag = (ab_wr_cnt < HIGH_LIM);
  assign b_high_fill_flag = (ba_wr_cnt < HIGH_LIM);

  // ************************************************************
  // Mailboxes
  // ************************************************************
  reg [DW-1:0] ab_mb_ff;
  reg [DW-1:0] ba_mb_ff;
  reg          ab_mflag_ff;
  reg          ba_mflag_ff;
  reg [DW-1:0] a_mbout_ff;
  reg [DW-1:0] b_mbout_ff;
  reg          a_src_mail_ff;
  reg          b_src_mail_ff;

  // New mail wins over a coincident read of the old mail
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ab_mb_ff      <= `BFP_DATA_RST;
      ba_mb_ff      <= `BFP_DATA_RST;
      ab_mflag_ff   <= `BFP_MAIL_EMPTY;
      ba_mflag_ff   <= `BFP_MAIL_EMPTY;
      a_mbout_ff    <= `BFP_DATA_RST;
      b_mbout_ff    <= `BFP_DATA_RST;
      a_src_mail_ff <= 1'b0;
      b_src_mail_ff <= 1'b0;
    end else begin
      if (a_mb_wr) begin
        ab_mb_ff    <= a_din_s;
        ab_mflag_ff <= `BFP_MAIL_FULL;
      end else if (b_mb_rd) begin
        ab_mflag_ff <= `BFP_MAIL_EMPTY;
      end
      if (b_mb_wr) begin
        ba_mb_ff    <= b_din_s;
        ba_mflag_ff <= `BFP_MAIL_FULL;
      end else if (a_mb_rd) begin
        ba_mflag_ff <= `BFP_MAIL_EMPTY;
      end
      if (a_mb_rd) begin
        a_mbout_ff    <= ba_mb_ff;
        a_src_mail_ff <= 1'b1;
      end else if (ba_ld) begin
        a_src_mail_ff <= 1'b0;
      end
      if (b_mb_rd) begin
        b_mbout_ff    <= ab_mb_ff;
        b_src_mail_ff <= 1'b1;
      end else if (ab_ld) begin
        b_src_mail_ff <= 1'b0;
      end
    end
  end

  assign a_to_b_mail_flag = ab_mflag_ff;
  assign b_to_a_mail_flag = ba_mflag_ff;
  assign a_data_o = a_src_mail_ff ? a_mbout_ff : ba_out_ff;
  assign b_data_o = b_src_mail_ff ? b_mbout_ff : ab_out_ff;
endmodule

// [tb/bfp_host.sv]
// Port host model: free port clock and the shared data bus
`timescale 1ns/1ps
module bfp_host #(
  parameter HALF = 4
) (
  input  wire        ref_clk,
  input  wire [35:0] dev_o,
  input  wire        dev_oe,
  input  wire [35:0] host_d,
  input  wire        host_oe,
  output reg         pclk,
  output wire [35:0] bus
);
  reg     [35:0] last_ff;
  integer        cnt;

  initial begin
    pclk    = 1'b0;
    cnt     = 0;
    last_ff = 36'h0;
  end

  // Undriven bus shows a pattern that flips every cycle
  assign bus = host_oe ? host_d : (dev_oe ? dev_o : ~last_ff);

  always @(posedge ref_clk) begin
    last_ff <= bus;
    cnt     <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      pclk <= #1 ~pclk;
  end
endmodule

// [tb/bfp_top_monitor.sv]
// Checker of bus enables, mail flags and read flags at the ports
`timescale 1ns/1ps
module bfp_top_monitor (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        a_clk,
  input wire        a_select_n,
  input wire        a_dir,
  input wire        a_enable,
  input wire        a_mail_sel,
  input wire        a_data_oe,
  input wire        a_avail_flag,
  input wire        b_clk,
  input wire        b_select_n,
  input wire        b_dir,
  input wire        b_enable,
  input wire        b_mail_sel,
  input wire [35:0] b_data_o,
  input wire        b_data_oe,
  input wire        b_avail_flag,
  input wire        a_to_b_mail_flag,
  input wire        b_to_a_mail_flag
);
  // ************************************************************
  // Port relations, pins seen through two sync stages
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_drive_a: assert property (
    a_data_oe == $past(!a_select_n && !a_dir, 2))
    else $error("port A bus enable wrong");
  b_drive_a: assert property (
    b_data_oe == $past(!b_select_n && b_dir, 2))
    else $error("port B bus enable wrong");
  a_mail_wr_a: assert property (
    $fell(a_to_b_mail_flag) |->
    $past(!a_select_n && a_dir && a_enable && a_mail_sel, 3))
    else $error("A to B mail flag fell without a write");
  b_mail_wr_a: assert property (
    $fell(b_to_a_mail_flag) |->
    $past(!b_select_n && !b_dir && b_enable && b_mail_sel, 3))
    else $error("B to A mail flag fell without a write");
  a_mail_rd_a: assert property (
    $rose(b_to_a_mail_flag) |->
    $past(!a_select_n && !a_dir && a_enable && a_mail_sel, 3))
    else $error("B to A mail flag rose without a read");
  b_mail_rd_a: assert property (
    $rose(a_to_b_mail_flag) |->
    $past(!b_select_n && b_dir && b_enable && b_mail_sel, 3))
    else $error("A to B mail flag rose without a read");
  b_avail_drop_a: assert property (
    $fell(b_avail_flag) |->
    $past(!b_select_n && b_dir && b_enable && !b_mail_sel, 3))
    else $error("port B read flag fell without a read");
  a_avail_dom_a: assert property (
    $changed(a_avail_flag) |-> $past(a_clk, 3) && !$past(a_clk, 4))
    else $error("port A read flag moved off its clock edge");
  b_avail_dom_a: assert property (
    $changed(b_avail_flag) |-> $past(b_clk, 3) && !$past(b_clk, 4))
    else $error("port B read flag moved off its clock edge");
  b_out_hold_a: assert property (
    !$stable(b_data_o) |-> b_avail_flag ||
    $past(!b_select_n && b_dir && b_enable, 3) ||
    $past(!b_select_n && b_dir && b_enable, 4))
    else $error("port B output changed without a load");
endmodule

bind bfp_top bfp_top_monitor u_mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .a_clk(a_clk),
  .a_select_n(a_select_n), .a_dir(a_dir), .a_enable(a_enable),
  .a_mail_sel(a_mail_sel), .a_data_oe(a_data_oe),
  .a_avail_flag(a_avail_flag), .b_clk(b_clk), .b_select_n(b_select_n),
  .b_dir(b_dir), .b_enable(b_enable), .b_mail_sel(b_mail_sel),
  .b_data_o(b_data_o), .b_data_oe(b_data_oe),
  .b_avail_flag(b_avail_flag), .a_to_b_mail_flag(a_to_b_mail_flag),
  .b_to_a_mail_flag(b_to_a_mail_flag));

// [tb/tb.sv]
// Testbench of the bidirectional queue port block
`timescale 1ns/1ps
module tb;
  localparam DEPTH = 16;
  reg         ref_clk;
  reg         rst_n;
  reg         mode;
  reg  [1:0]  sn;
  reg  [1:0]  dr;
  reg  [1:0]  en;
  reg  [1:0]  mb;
  reg  [1:0]  hoe;
  reg  [35:0] hd [0:1];
  wire [35:0] bus [0:1];
  wire [35:0] dat [0:1];
  wire [1:0]  pclk, oe, avail, space, lowf, highf, mailf;
  integer     miscompares, checks, cyc, i;

  bfp_top #(.DEPTH(DEPTH), .LOW_OFS(2), .HIGH_OFS(2)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .endian_timing_select(mode),
    .a_clk(pclk[0]), .a_select_n(sn[0]), .a_dir(dr[0]), .a_enable(en[0]),
    .a_mail_sel(mb[0]), .a_data_i(bus[0]), .a_data_o(dat[0]),
    .a_data_oe(oe[0]), .a_avail_flag(avail[0]), .a_space_flag(space[0]),
    .a_low_fill_flag(lowf[0]), .a_high_fill_flag(highf[0]),
    .b_clk(pclk[1]), .b_select_n(sn[1]), .b_dir(dr[1]), .b_enable(en[1]),
    .b_mail_sel(mb[1]), .b_data_i(bus[1]), .b_data_o(dat[1]),
    .b_data_oe(oe[1]), .b_avail_flag(avail[1]), .b_space_flag(space[1]),
    .b_low_fill_flag(lowf[1]), .b_high_fill_flag(highf[1]),
    .a_to_b_mail_flag(mailf[0]), .b_to_a_mail_flag(mailf[1]));

  genvar g;
  for (g = 0; g < 2; g = g + 1) begin : gh
    bfp_host #(.HALF(4 + g)) host (.ref_clk(ref_clk), .dev_o(dat[g]),
      .dev_oe(oe[g]), .host_d(hd[g]), .host_oe(hoe[g]), .pclk(pclk[g]),
      .bus(bus[g]));
  end

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ************************************************************
  // Port cycles and comparison
  // ************************************************************
  task chk(input [35:0] got, input [35:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: seen %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Pins set while the port clock is low, held past its rising edge
  task automatic op(input int p, input bit s, d, e, m, input [35:0] w);
    begin
      @(negedge pclk[p]);
      @(posedge ref_clk);
      #1;
      {sn[p], dr[p], en[p], mb[p]} = {s, d, e, m};
      hd[p] = w;
      hoe[p] = !s && (d != p);
      @(posedge pclk[p]);
      @(negedge pclk[p]);
      @(posedge ref_clk);
      #1;
      en[p] = 1'b0;
      hoe[p] = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
    end
  endtask

  task automatic wt(input int p, input int n);
    begin
      repeat (n) @(posedge pclk[p]);
      repeat (4) @(posedge ref_clk);
      #1;
    end
  endtask

  task automatic rst(input bit md);
    begin
      @(posedge ref_clk);
      #1;
      rst_n = 1'b0;
      mode = md;
      sn = 2'b11;
      en = 2'b00;
      repeat (4) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      wt(0, 3);
      wt(1, 3);
    end
  endtask

  task results;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      results;
    end
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    {miscompares, checks, cyc} = 0;
    {rst_n, mode, sn, dr, en, mb, hoe} = 12'h300;
    hd[0] = 36'h0;
    hd[1] = 36'h0;
    rst(1'b0);
    chk(avail, 2'b00);
    chk({space, highf, mailf, oe}, 8'hfc);
    chk(lowf, 2'b00);
    for (i = 0; i < 2; i++) begin
      op(i, 0, i, 0, 0, 36'h0);
      chk(oe[i], 1'b1);
      op(i, 0, !i, 0, 0, 36'h5a);
      chk(oe[i], 1'b0);
    end
    wt(0, 4);
    chk(avail, 2'b00);
    op(0, 0, 1, 1, 0, 36'h123456789);
    wt(1, 1);
    chk(avail[1], 1'b0);
    wt(1, 2);
    chk(avail[1], 1'b1);
    chk(dat[1], 36'h123456789);
    op(0, 0, 1, 1, 0, 36'hfedcba987);
    wt(1, 4);
    chk(dat[1], 36'h123456789);
    op(1, 0, 1, 1, 0, 36'h0);
    chk(avail[1], 1'b1);
    chk(dat[1], 36'hfedcba987);
    op(1, 0, 1, 1, 0, 36'h0);
    chk(avail[1], 1'b0);
    op(1, 0, 1, 1, 0, 36'h0);
    chk(dat[1], 36'hfedcba987);
    for (i = 0; i < 2; i++) begin
      op(i, 0, !i, 1, 1, 36'hc0de0 + i);
      chk(mailf[i], 1'b0);
      chk({avail, space}, 4'b0011);
      op(1 - i, 0, 1 - i, 1, 1, 36'h0);
      chk(dat[1 - i], 36'hc0de0 + i);
      chk(mailf[i], 1'b1);
    end
    for (i = 0; i < DEPTH + 4; i++)
      op(0, 0, 1, 1, 0, 36'h100 + i);
    chk({space[0], highf[0], lowf[1]}, 3'b001);
    for (i = 0; i <= DEPTH; i++) begin
      chk(dat[1], 36'h100 + i);
      op(1, 0, 1, 1, 0, 36'h0);
    end
    chk(avail[1], 1'b0);
    chk(dat[1], 36'h100 + DEPTH);
    fork
      op(0, 0, 1, 1, 0, 36'haaa);
      op(1, 0, 0, 1, 0, 36'hbbb);
    join
    wt(0, 4);
    wt(1, 4);
    chk(dat[1], 36'haaa);
    chk(dat[0], 36'hbbb);
    rst(1'b1);
    chk(avail, 2'b00);
    op(1, 0, 0, 1, 0, 36'hf00d);
    chk(avail[0], 1'b0);
    wt(0, 2);
    chk(avail[0], 1'b1);
    chk(dat[0], 36'h0);
    op(0, 0, 0, 1, 0, 36'h0);
    chk(dat[0], 36'hf00d);
    chk(avail[0], 1'b0);
    op(0, 0, 0, 1, 0, 36'h0);
    chk(dat[0], 36'hf00d);
    results;
  end
endmodule
